//--- airo_consts.svh
`ifndef AIRO_CONSTS_SVH
`define AIRO_CONSTS_SVH

// Register addresses on the internal register port.
`define AIRO_ADDR_SRC_ENABLE 8'h2D
`define AIRO_ADDR_PIN_SELECT 8'h2E
`define AIRO_ADDR_X_ADJUST 8'h2F
`define AIRO_ADDR_Y_ADJUST 8'h30
`define AIRO_ADDR_Z_ADJUST 8'h31

// Bit positions shared by the enable and pin select registers.
`define AIRO_BIT_SLEEP_WAKE 7
`define AIRO_BIT_FIFO 6
`define AIRO_BIT_TRANSIENT 5
`define AIRO_BIT_ORIENTATION 4
`define AIRO_BIT_PULSE 3
`define AIRO_BIT_FALL_MOTION 2
`define AIRO_BIT_FIXED_ZERO 1
`define AIRO_BIT_SAMPLE_READY 0

// Writable bits of the enable and pin select registers; bit 1 is fixed at zero.
`define AIRO_SRC_MASK 8'hFD

// Reset values.
`define AIRO_RST_SRC_ENABLE 8'h00
`define AIRO_RST_PIN_SELECT 8'h00
`define AIRO_RST_ADJUST 8'h00

// Offset weight in micro-g per count, and the nominal span in milli-g.
`define AIRO_ADJUST_UG_PER_LSB 1960
`define AIRO_ADJUST_SPAN_MG 250

`endif

//--- airo_host_model.sv
`timescale 1ns/1ps
module airo_host_model (
  // Lines as driven, their polarity and the events seen.
  input wire logic irq_line_a_o,
  input wire logic irq_line_a_oe_n,
  input wire logic irq_line_b_o,
  input wire logic irq_line_b_oe_n,
  input wire logic irq_level_polarity,
  output logic seen_a,
  output logic seen_b,
  output logic src_read_req
);
  // A released line floats up on the board pull-up, so only a line pulled low reads low.
  assign seen_a = (irq_line_a_oe_n | irq_line_a_o) ^ !irq_level_polarity;
  assign seen_b = (irq_line_b_oe_n | irq_line_b_o) ^ !irq_level_polarity;
  // Either line active sends the host off to read the interrupt source register.
  assign src_read_req = seen_a | seen_b;
endmodule // airo_host_model

//--- airo_irq_route.sv
`timescale 1ns/1ps
`include "airo_consts.svh"

module airo_irq_route #(
  parameter int SAMPLE_W = 12,
  parameter int ADJ_SHIFT = 0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port, one access per strobe.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Pin style settings from the pin configuration register.
  input wire logic irq_level_polarity,
  input wire logic irq_drive_style,
  // Event flags from the detectors, bit positions as the enable register.
  input wire logic [7:0] evt_flags,
  // Raw axis samples and corrected results.
  input wire logic signed [SAMPLE_W-1:0] x_sample,
  input wire logic signed [SAMPLE_W-1:0] y_sample,
  input wire logic signed [SAMPLE_W-1:0] z_sample,
  output logic signed [SAMPLE_W-1:0] x_corrected,
  output logic signed [SAMPLE_W-1:0] y_corrected,
  output logic signed [SAMPLE_W-1:0] z_corrected,
  // Interrupt lines; output enable is low while the line is driven.
  output logic irq_line_a_o,
  output logic irq_line_a_oe_n,
  output logic irq_line_b_o,
  output logic irq_line_b_oe_n
);

  airo_pkg::airo_reg_t irq_source_enable_r;
  airo_pkg::airo_reg_t irq_pin_select_r;
  airo_pkg::airo_adjust_t x_axis_zero_adjust_r;
  airo_pkg::airo_adjust_t y_axis_zero_adjust_r;
  airo_pkg::airo_adjust_t z_axis_zero_adjust_r;
  logic [7:0] gated_flags;
  logic line_a_active;
  logic line_b_active;
  logic line_a_r;
  logic line_b_r;
  logic line_a_nxt;
  logic line_b_nxt;
  airo_pkg::airo_drive_e drive_mode;
  // Write strobes per register, decoded once so each register block stays small.
  logic wr_src_enable;
  logic wr_pin_select;
  logic wr_x_adjust;
  logic wr_y_adjust;
  logic wr_z_adjust;
  // Named views of the enable and pin select fields, one per source.
  logic en_sleep_wake_evt;
  logic en_fifo_evt;
  logic en_transient_evt;
  logic en_orientation_evt;
  logic en_pulse_evt;
  logic en_fall_motion_evt;
  logic en_sample_ready_evt;
  logic sel_sleep_wake_pin;
  logic sel_fifo_pin;
  logic sel_transient_pin;
  logic sel_orientation_pin;
  logic sel_pulse_pin;
  logic sel_fall_motion_pin;
  logic sel_sample_ready_pin;
  logic [7:0] src_enable_bits;
  logic [7:0] src_pin_bits;

  // Saturating add keeps a large offset from wrapping a sample near full scale.
  function automatic logic signed [SAMPLE_W-1:0] apply_adjust(
    input logic signed [SAMPLE_W-1:0] sample,
    input logic signed [7:0] adjust
  );
    logic signed [SAMPLE_W+8:0] sum;
    logic signed [SAMPLE_W+8:0] max_v;
    logic signed [SAMPLE_W+8:0] min_v;
    sum = (SAMPLE_W+9)'(sample) + ((SAMPLE_W+9)'(adjust) <<< ADJ_SHIFT);
    max_v = (SAMPLE_W+9)'({1'b0, {(SAMPLE_W-1){1'b1}}});
    min_v = -max_v - (SAMPLE_W+9)'(1);
    if (sum > max_v) begin
      apply_adjust = max_v[SAMPLE_W-1:0];
    end else if (sum < min_v) begin
      apply_adjust = min_v[SAMPLE_W-1:0];
    end else begin
      apply_adjust = sum[SAMPLE_W-1:0];
    end
  endfunction

  // Exact match of the register address against one map entry.
  function automatic logic addr_is(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_is = (addr == target);
  endfunction

  // True for any address inside the block's register map.
  function automatic logic addr_in_map(
    input logic [7:0] addr
  );
    addr_in_map = (addr >= `AIRO_ADDR_SRC_ENABLE) && (addr <= `AIRO_ADDR_Z_ADJUST);
  endfunction

  // Clears the bit that has no source behind it, in both shared-layout registers.
  function automatic logic [7:0] mask_fixed(
    input logic [7:0] value
  );
    mask_fixed = value & `AIRO_SRC_MASK;
  endfunction

  // Any already gated flag that is steered to the asked-for line.
  function automatic logic route_any(
    input logic [7:0] flags,
    input logic [7:0] pins,
    input logic want_first
  );
    logic [7:0] picked;
    picked = want_first ? pins : ~pins;
    route_any = |(flags & picked);
  endfunction

  // Pin level for a line: active shows as the polarity value, idle as its inverse.
  function automatic logic line_level(
    input logic active,
    input logic polarity
  );
    line_level = polarity ? active : ~active;
  endfunction

  // A write and a read may share one strobe cycle; only the write is decoded here.
  always_comb begin
    wr_src_enable = reg_wr && addr_is(reg_addr, `AIRO_ADDR_SRC_ENABLE);
    wr_pin_select = reg_wr && addr_is(reg_addr, `AIRO_ADDR_PIN_SELECT);
    wr_x_adjust = reg_wr && addr_is(reg_addr, `AIRO_ADDR_X_ADJUST);
    wr_y_adjust = reg_wr && addr_is(reg_addr, `AIRO_ADDR_Y_ADJUST);
    wr_z_adjust = reg_wr && addr_is(reg_addr, `AIRO_ADDR_Z_ADJUST);
  end

  // Bit 1 has no source behind it and stays zero in both vectors.
  always_comb begin
    en_sleep_wake_evt = irq_source_enable_r[`AIRO_BIT_SLEEP_WAKE];
    en_fifo_evt = irq_source_enable_r[`AIRO_BIT_FIFO];
    en_transient_evt = irq_source_enable_r[`AIRO_BIT_TRANSIENT];
    en_orientation_evt = irq_source_enable_r[`AIRO_BIT_ORIENTATION];
    en_pulse_evt = irq_source_enable_r[`AIRO_BIT_PULSE];
    en_fall_motion_evt = irq_source_enable_r[`AIRO_BIT_FALL_MOTION];
    en_sample_ready_evt = irq_source_enable_r[`AIRO_BIT_SAMPLE_READY];
    sel_sleep_wake_pin = irq_pin_select_r[`AIRO_BIT_SLEEP_WAKE];
    sel_fifo_pin = irq_pin_select_r[`AIRO_BIT_FIFO];
    sel_transient_pin = irq_pin_select_r[`AIRO_BIT_TRANSIENT];
    sel_orientation_pin = irq_pin_select_r[`AIRO_BIT_ORIENTATION];
    sel_pulse_pin = irq_pin_select_r[`AIRO_BIT_PULSE];
    sel_fall_motion_pin = irq_pin_select_r[`AIRO_BIT_FALL_MOTION];
    sel_sample_ready_pin = irq_pin_select_r[`AIRO_BIT_SAMPLE_READY];
    src_enable_bits = {en_sleep_wake_evt, en_fifo_evt, en_transient_evt, en_orientation_evt,
      en_pulse_evt, en_fall_motion_evt, 1'b0, en_sample_ready_evt};
    src_pin_bits = {sel_sleep_wake_pin, sel_fifo_pin, sel_transient_pin, sel_orientation_pin,
      sel_pulse_pin, sel_fall_motion_pin, 1'b0, sel_sample_ready_pin};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_source_enable_r <= `AIRO_RST_SRC_ENABLE;
    end else if (wr_src_enable) begin
      irq_source_enable_r <= mask_fixed(reg_wdata);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_pin_select_r <= `AIRO_RST_PIN_SELECT;
    end else if (wr_pin_select) begin
      irq_pin_select_r <= mask_fixed(reg_wdata);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      x_axis_zero_adjust_r <= `AIRO_RST_ADJUST;
    end else if (wr_x_adjust) begin
      x_axis_zero_adjust_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      y_axis_zero_adjust_r <= `AIRO_RST_ADJUST;
    end else if (wr_y_adjust) begin
      y_axis_zero_adjust_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      z_axis_zero_adjust_r <= `AIRO_RST_ADJUST;
    end else if (wr_z_adjust) begin
      z_axis_zero_adjust_r <= reg_wdata;
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AIRO_ADDR_SRC_ENABLE: begin
          reg_rdata <= irq_source_enable_r;
        end
        `AIRO_ADDR_PIN_SELECT: begin
          reg_rdata <= irq_pin_select_r;
        end
        `AIRO_ADDR_X_ADJUST: begin
          reg_rdata <= x_axis_zero_adjust_r;
        end
        `AIRO_ADDR_Y_ADJUST: begin
          reg_rdata <= y_axis_zero_adjust_r;
        end
        `AIRO_ADDR_Z_ADJUST: begin
          reg_rdata <= z_axis_zero_adjust_r;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    reg_hit = addr_in_map(reg_addr);
  end

  // The routing is purely combinational up to one output flop, so an event reaches its line one cycle later.
  always_comb begin
    gated_flags = mask_fixed(evt_flags & src_enable_bits);
    line_a_active = route_any(gated_flags, src_pin_bits, 1'b1);
    line_b_active = route_any(gated_flags, src_pin_bits, 1'b0);
    line_a_nxt = line_level(line_a_active, irq_level_polarity);
    line_b_nxt = line_level(line_b_active, irq_level_polarity);
    drive_mode = irq_drive_style ? airo_pkg::AIRO_OPEN_DRAIN : airo_pkg::AIRO_PUSH_PULL;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // Reset loads the idle level for the current polarity, so no line flashes active.
      line_a_r <= ~irq_level_polarity;
      line_b_r <= ~irq_level_polarity;
    end else begin
      line_a_r <= line_a_nxt;
      line_b_r <= line_b_nxt;
    end
  end

  // In open-drain mode the line is only pulled low; a high level is left to the pull-up.
  always_comb begin
    irq_line_a_o = line_a_r;
    irq_line_b_o = line_b_r;
    if (drive_mode == airo_pkg::AIRO_OPEN_DRAIN) begin
      irq_line_a_o = 1'b0;
      irq_line_b_o = 1'b0;
      irq_line_a_oe_n = line_a_r;
      irq_line_b_oe_n = line_b_r;
    end else begin
      irq_line_a_oe_n = 1'b0;
      irq_line_b_oe_n = 1'b0;
    end
  end

  // One count is nominally 1.96 mg; ADJ_SHIFT scales it to the sample's own weight.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      x_corrected <= '0;
      y_corrected <= '0;
      z_corrected <= '0;
    end else begin
      x_corrected <= apply_adjust(x_sample, x_axis_zero_adjust_r);
      y_corrected <= apply_adjust(y_sample, y_axis_zero_adjust_r);
      z_corrected <= apply_adjust(z_sample, z_axis_zero_adjust_r);
    end
  end

endmodule // airo_irq_route

//--- airo_irq_route_assertions.sv
`timescale 1ns/1ps
module airo_irq_route_assertions (
  // Watched ports of the routing block.
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_level_polarity,
  input wire logic irq_drive_style,
  input wire logic [7:0] evt_flags,
  input wire logic irq_line_a_o,
  input wire logic irq_line_a_oe_n,
  input wire logic irq_line_b_o,
  input wire logic irq_line_b_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence adj_wr; reg_wr && reg_addr inside {[8'h2F:8'h31]}; endsequence
  sequence same_rd; reg_rd && !reg_wr && reg_addr == $past(reg_addr); endsequence
  a_pp_drive: assert property (!irq_drive_style |-> !irq_line_a_oe_n && !irq_line_b_oe_n) else $error("released");
  a_od_drive: assert property (irq_drive_style |-> !irq_line_a_o && !irq_line_b_o) else $error("driven high");
  a_rd_unmapped: assert property (reg_rd && !(reg_addr inside {[8'h2D:8'h31]}) |=> !reg_rdata)
    else $error("unmapped read");
  a_fixed_zero: assert property (reg_rd && reg_addr inside {8'h2D, 8'h2E} |=> !reg_rdata[1])
    else $error("fixed bit set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_adj_rdback: assert property (adj_wr ##1 same_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("offset readback");
  a_idle_a: assert property (!(evt_flags & 8'hFD) |=>
    (irq_line_a_oe_n | irq_line_a_o) != $past(irq_level_polarity)) else $error("line a active");
  a_idle_b: assert property (!(evt_flags & 8'hFD) |=>
    (irq_line_b_oe_n | irq_line_b_o) != $past(irq_level_polarity)) else $error("line b active");
endmodule // airo_irq_route_assertions
bind airo_irq_route airo_irq_route_assertions i_airo_irq_route_assertions (.*);

//--- airo_irq_route_tb_top.sv
`timescale 1ns/1ps
module airo_irq_route_tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, seen_a, seen_b, src_read_req;
  logic irq_level_polarity = 1'b0, irq_drive_style = 1'b0, irq_line_a_o, irq_line_a_oe_n, irq_line_b_o, irq_line_b_oe_n;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, evt_flags = 8'h00, reg_rdata;
  logic signed [11:0] x_sample = 12'h000, y_sample = 12'h000, z_sample = 12'h000, x_corrected, y_corrected, z_corrected;
  int miscompares = 0, comparisons = 0, seed = 77165, en = 0, sel = 0, t;
  int off [3] = '{0, 0, 0};
  airo_irq_route #(.SAMPLE_W(12), .ADJ_SHIFT(0)) i_airo_irq_route (.*);
  airo_host_model i_airo_host_model (.*);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic int sat12(input int v);
    return v > 2047 ? 2047 : v < -2048 ? -2048 : v;
  endfunction
  task automatic acc(input logic w, input logic r, input int a, input int d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= 8'(a);
    reg_wdata <= 8'(d);
    if (w && a == 8'h2D) en = d & 8'hFD;
    if (w && a == 8'h2E) sel = d & 8'hFD;
    if (w && a inside {[8'h2F:8'h31]}) off[a - 8'h2F] = int'($signed(8'(d)));
    @(posedge sys_clk);
  endtask
  task automatic rd(input int a);
    acc(0, 1, a, 0);
    chk(reg_hit, 16'(a inside {[8'h2D:8'h31]}));
    acc(0, 0, 0, 0);
    chk(reg_rdata, 16'(a == 8'h2D ? en : a == 8'h2E ? sel :
      a inside {[8'h2F:8'h31]} ? off[a - 8'h2F] & 8'hFF : 0));
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 8'h2C; a < 8'h33; a++)
      rd(a);
    repeat (300) begin
      t = 8'h2B + ($random(seed) & 7);
      acc(1, 0, t, $random(seed));
      rd(t);
      evt_flags <= 8'($random(seed));
      irq_level_polarity <= 1'($random(seed));
      irq_drive_style <= 1'($random(seed));
      x_sample <= 12'($random(seed));
      y_sample <= 12'($random(seed));
      z_sample <= 12'($random(seed));
      acc(0, 0, 0, 0);
      acc(0, 0, 0, 0);
      chk(seen_a, 16'(|(evt_flags & en & sel)));
      chk(seen_b, 16'(|(evt_flags & en & ~sel)));
      chk(src_read_req, 16'(|(evt_flags & en)));
      chk(x_corrected, 16'(sat12(x_sample + off[0])));
      chk(y_corrected, 16'(sat12(y_sample + off[1])));
      chk(z_corrected, 16'(sat12(z_sample + off[2])));
    end
    end_sim();
  end
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule // airo_irq_route_tb_top

//--- airo_pkg.sv
package airo_pkg;
  typedef logic [7:0] airo_reg_t;
  typedef logic signed [7:0] airo_adjust_t;
  typedef enum logic {
    AIRO_PUSH_PULL,
    AIRO_OPEN_DRAIN
  } airo_drive_e;
endpackage
